// [hw/btn_debounce.sv]
// shift-register debouncer for one active-low pushbutton line
`timescale 1ns/1ps
module btn_debounce #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // sample tick and synchronised line
  input  wire logic tick_i,
  input  wire logic line_i,
  // stable level
  output logic      level_o
);
  logic [DEPTH-1:0] shift_ff;
  logic [DEPTH-1:0] nxt_shift;
  logic             level_ff;
  logic             nxt_level;

  // idle line is high (switch open), so reset to all ones
  always_comb
  begin
    nxt_shift = shift_ff;
    nxt_level = level_ff;
    if (tick_i)
    begin
      nxt_shift = {shift_ff[DEPTH-2:0], line_i};
    end
    if (&shift_ff)
    begin
      nxt_level = 1'b1;
    end
    else if (~|shift_ff)
    begin
      nxt_level = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      shift_ff <= '1;
      level_ff <= 1'b1;
    end
    else
    begin
      shift_ff <= nxt_shift;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule : btn_debounce

// [hw/fp_pkg.sv]
// shared constants for the front panel input interface
package fp_pkg;
  // ----------------------------------------------------------------
  // register byte addresses (8 address lines)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_KEYS  = 8'h00;
  localparam logic [7:0] ADDR_ENC   = 8'h04;
  localparam logic [7:0] ADDR_MODE  = 8'h08;
  localparam logic [7:0] ADDR_BRITE = 8'h0C;
  localparam logic [7:0] ADDR_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_LEDS  = 8'h14;
  localparam logic [7:0] ADDR_ISTAT = 8'h18;
  localparam logic [7:0] ADDR_IMASK = 8'h1C;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          KEY_CODE_W   = 4;
  localparam int          BTN_LSB      = 8;
  localparam int          NUM_KEYS     = 15;
  localparam int          NUM_MODES    = 10;
  localparam int          CTRL_CLR_BIT = 0;
  localparam int          IRQ_W        = 3;
  localparam logic [3:0]  KEY_NONE     = 4'hF;
  localparam logic [3:0]  MODE_RST     = 4'h0;
  localparam logic [3:0]  MODE_MAX     = 4'h9;
  localparam logic [1:0]  BRITE_RST    = 2'h0;

  typedef enum logic [1:0] {BRITE_OFF, BRITE_QTR, BRITE_HALF, BRITE_FULL} brite_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int DEB_TICK_NS   = 1000000;
  localparam int DEB_TICK_CYC  = DEB_TICK_NS / CLK_NS;
  localparam int SCAN_TICK_NS  = 250000;
  localparam int SCAN_TICK_CYC = SCAN_TICK_NS / CLK_NS;
  localparam int DEB_DEPTH     = 4;
endpackage : fp_pkg

// [hw/front_panel_if.sv]
// front panel input interface: buttons, keypad, encoders, indicators, brightness
//
// What this block does
// - mode code drives exactly one of ten lightbars
// - brightness off, quarter, half, full by duty
// - processor bus: data, address, read, write, clear
// - processor interrupt request held inactive
// - pushbuttons are active low
// - debouncer output changes only when stages agree
// - debouncers shift on their own slow tick
// - keypad code is complement of top priority
// - higher key overrides, lower keys ignored
// - digits 1-10, point 11, H K M, clear 15
// - keypad code and buttons readable on bus
// - encoder trigger line plus direction level
// - trigger sets event flag, captures direction
// - encoder flags driven during their read and for one cycle after it
// - end of encoder read clears the flags
// - bus clear resets all written latches
// - read words hold steady during read strobe
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module front_panel_if
  import fp_pkg::*;
#(
  parameter int N_BTN     = 8,
  parameter int N_LED     = 8,
  parameter int DEB_DIV   = DEB_TICK_CYC,
  parameter int SCAN_DIV  = SCAN_TICK_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 srst_i,
  // apb slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // panel inputs; keys and buttons active low, encoder trigger active high (rising edge)
  input  wire logic [NUM_KEYS-1:0]  key_n_i,
  input  wire logic [N_BTN-1:0]     btn_n_i,
  input  wire logic [1:0]           enc_trig_i,
  input  wire logic [1:0]           enc_dir_i,
  // panel outputs
  output logic [NUM_MODES-1:0]      mode_bar_o,
  output logic [N_LED-1:0]          led_o,
  output logic                      scan_en_o,
  // interrupts
  output logic                      irq_o,
  output logic                      proc_irq_o
);
  import fp_pkg::*;

  localparam int NSYNC = NUM_KEYS + N_BTN + 4;

  // ----------------------------------------------------------------
  // synchronisers and debouncers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0]           sync1_ff;
  logic [NSYNC-1:0]           sync2_ff;
  logic [31:0]                deb_cnt_ff;
  logic [31:0]                nxt_deb_cnt;
  logic                       deb_tick;
  logic [NUM_KEYS+N_BTN-1:0]  deb_lvl;
  logic [KEY_CODE_W-1:0]      key_code;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end
    else
    begin
      sync1_ff <= {enc_dir_i, enc_trig_i, btn_n_i, key_n_i};
      sync2_ff <= sync1_ff;
    end
  end

  // local divider, not tied to bus activity
  always_comb
  begin
    deb_tick    = (deb_cnt_ff == 32'(DEB_DIV - 1));
    nxt_deb_cnt = deb_tick ? '0 : deb_cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      deb_cnt_ff <= '0;
    end
    else
    begin
      deb_cnt_ff <= nxt_deb_cnt;
    end
  end

  for (genvar g = 0; g < NUM_KEYS + N_BTN; g++)
  begin : g_deb
    btn_debounce #(.DEPTH(DEB_DEPTH)) u_deb (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .tick_i    (deb_tick),
      .line_i    (sync2_ff[g]),
      .level_o   (deb_lvl[g])
    );
  end

  key_encoder u_keys (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pressed_i (~deb_lvl[NUM_KEYS-1:0]),
    .code_o    (key_code)
  );

  // ----------------------------------------------------------------
  // shaft encoders
  // ----------------------------------------------------------------
  logic [1:0] trig_s;
  logic [1:0] dir_s;
  logic [1:0] trig_d_ff;
  logic [1:0] trig_edge;
  logic [1:0] ev_ff;
  logic [1:0] dir_ff;
  logic [1:0] nxt_ev;
  logic [1:0] nxt_dir;
  logic       enc_clr_ff;
  logic       nxt_enc_clr;
  logic [1:0] snap_ev_ff;

  assign trig_s    = sync2_ff[NUM_KEYS+N_BTN +: 2];
  assign dir_s     = sync2_ff[NUM_KEYS+N_BTN+2 +: 2];
  assign trig_edge = trig_s & ~trig_d_ff;

  // only flags seen by the read are cleared, so a late trigger survives
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      nxt_ev[i]  = ev_ff[i];
      nxt_dir[i] = dir_ff[i];
      if (trig_edge[i])
      begin
        nxt_ev[i]  = 1'b1;
        nxt_dir[i] = dir_s[i];
      end
      else if (enc_clr_ff && snap_ev_ff[i])
      begin
        nxt_ev[i]  = 1'b0;
        nxt_dir[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      // synchroniser resets high, so a low start here would fake a trigger edge
      trig_d_ff <= '1;
      ev_ff     <= '0;
      dir_ff    <= '0;
    end
    else
    begin
      trig_d_ff <= trig_s;
      ev_ff     <= nxt_ev;
      dir_ff    <= nxt_dir;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and latches
  // ----------------------------------------------------------------
  logic                   rd_setup;
  logic                   wr_acc;
  logic                   rd_done;
  logic                   mapped;
  logic [31:0]            keys_word;
  logic [31:0]            snap_keys_ff;
  logic [31:0]            nxt_snap_keys;
  logic [3:0]             snap_enc_ff;
  logic [3:0]             nxt_snap_enc;
  logic [1:0]             nxt_snap_ev;
  logic [31:0]            prdata_ff;
  logic [31:0]            nxt_prdata;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic                   nxt_pslverr;
  logic [3:0]             mode_ff;
  logic [3:0]             nxt_mode;
  logic [1:0]             brite_ff;
  logic [1:0]             nxt_brite;
  logic [N_LED-1:0]       led_ff;
  logic [N_LED-1:0]       nxt_led;
  logic [IRQ_W-1:0]       istat_ff;
  logic [IRQ_W-1:0]       nxt_istat;
  logic [IRQ_W-1:0]       imask_ff;
  logic [IRQ_W-1:0]       nxt_imask;
  logic [KEY_CODE_W-1:0]  key_prev_ff;
  logic                   bus_clr;

  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {ADDR_KEYS, ADDR_ENC, ADDR_MODE, ADDR_BRITE,
                     ADDR_CTRL, ADDR_LEDS, ADDR_ISTAT, ADDR_IMASK};
  endfunction : is_mapped

  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign wr_acc    = psel_i && penable_i && pwrite_i && pready_ff;
  assign rd_done   = psel_i && penable_i && !pwrite_i && pready_ff;
  assign mapped    = is_mapped(paddr_i);
  assign bus_clr   = wr_acc && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_CLR_BIT];
  assign keys_word = {{(32-BTN_LSB-N_BTN){1'b0}}, deb_lvl[NUM_KEYS +: N_BTN],
                      {(BTN_LSB-KEY_CODE_W){1'b0}}, key_code};

  always_comb
  begin
    nxt_snap_keys = snap_keys_ff;
    nxt_snap_enc  = snap_enc_ff;
    nxt_snap_ev   = snap_ev_ff;
    nxt_prdata    = prdata_ff;
    nxt_pslverr   = 1'b0;
    nxt_enc_clr   = 1'b0;
    if (!(psel_i && !pwrite_i))
    begin
      nxt_snap_keys = keys_word;
      nxt_snap_enc  = {dir_ff[1], ev_ff[1], dir_ff[0], ev_ff[0]};
    end
    if (rd_setup)
    begin
      nxt_pslverr = !mapped;
      unique case (paddr_i)
        ADDR_KEYS:  nxt_prdata = keys_word;
        ADDR_ENC:   nxt_prdata = {28'h0, dir_ff[1], ev_ff[1], dir_ff[0], ev_ff[0]};
        ADDR_MODE:  nxt_prdata = {28'h0, mode_ff};
        ADDR_BRITE: nxt_prdata = {30'h0, brite_ff};
        ADDR_LEDS:  nxt_prdata = {{(32-N_LED){1'b0}}, led_ff};
        ADDR_ISTAT: nxt_prdata = {{(32-IRQ_W){1'b0}}, istat_ff};
        ADDR_IMASK: nxt_prdata = {{(32-IRQ_W){1'b0}}, imask_ff};
        default:    nxt_prdata = 32'h0;
      endcase
      if (paddr_i == ADDR_ENC)
      begin
        nxt_snap_ev = ev_ff;
      end
    end
    else if (!(psel_i && !pwrite_i))
    begin
      nxt_prdata = 32'h0;
    end
    else if (paddr_i == ADDR_KEYS)
    begin
      nxt_prdata = snap_keys_ff;
    end
    else if (paddr_i == ADDR_ENC)
    begin
      nxt_prdata = {28'h0, snap_enc_ff};
    end
    if (rd_done && paddr_i == ADDR_ENC)
    begin
      nxt_enc_clr = 1'b1;
    end
  end

  always_comb
  begin
    nxt_mode  = mode_ff;
    nxt_brite = brite_ff;
    nxt_led   = led_ff;
    nxt_imask = imask_ff;
    nxt_istat = istat_ff;
    if (wr_acc && paddr_i == ADDR_ISTAT)
    begin
      nxt_istat = istat_ff & ~pwdata_i[IRQ_W-1:0];
    end
    // new events win over a same-cycle clear
    nxt_istat = nxt_istat | {trig_edge, key_code != key_prev_ff};
    if (bus_clr)
    begin
      nxt_mode  = MODE_RST;
      nxt_brite = BRITE_RST;
      nxt_led   = '0;
      nxt_imask = '0;
    end
    else if (wr_acc)
    begin
      unique case (paddr_i)
        ADDR_MODE:
        begin
          // codes past nine would light nothing, so they are refused
          if (pwdata_i[3:0] <= MODE_MAX)
          begin
            nxt_mode = pwdata_i[3:0];
          end
        end
        ADDR_BRITE: nxt_brite = pwdata_i[1:0];
        ADDR_LEDS:  nxt_led   = pwdata_i[N_LED-1:0];
        ADDR_IMASK: nxt_imask = pwdata_i[IRQ_W-1:0];
        default:    nxt_led   = led_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      snap_keys_ff <= '0;
      snap_enc_ff  <= '0;
      snap_ev_ff   <= '0;
      prdata_ff    <= '0;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      enc_clr_ff   <= 1'b0;
      mode_ff      <= MODE_RST;
      brite_ff     <= BRITE_RST;
      led_ff       <= '0;
      istat_ff     <= '0;
      imask_ff     <= '0;
      key_prev_ff  <= KEY_NONE;
    end
    else
    begin
      snap_keys_ff <= nxt_snap_keys;
      snap_enc_ff  <= nxt_snap_enc;
      snap_ev_ff   <= nxt_snap_ev;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= psel_i && !penable_i;
      pslverr_ff   <= nxt_pslverr;
      enc_clr_ff   <= nxt_enc_clr;
      mode_ff      <= nxt_mode;
      brite_ff     <= nxt_brite;
      led_ff       <= nxt_led;
      istat_ff     <= nxt_istat;
      imask_ff     <= nxt_imask;
      key_prev_ff  <= key_code;
    end
  end

  // ----------------------------------------------------------------
  // indicators, brightness and interrupt
  // ----------------------------------------------------------------
  logic [31:0]          scan_cnt_ff;
  logic [31:0]          nxt_scan_cnt;
  logic [1:0]           phase_ff;
  logic [1:0]           nxt_phase;
  logic                 scan_tick;
  logic                 nxt_scan_en;
  logic                 scan_en_ff;
  logic [NUM_MODES-1:0] bar_ff;
  logic                 irq_ff;

  always_comb
  begin
    scan_tick    = (scan_cnt_ff == 32'(SCAN_DIV - 1));
    nxt_scan_cnt = scan_tick ? '0 : scan_cnt_ff + 32'h1;
    nxt_phase    = scan_tick ? phase_ff + 2'h1 : phase_ff;
    unique case (brite_t'(brite_ff))
      BRITE_OFF:  nxt_scan_en = 1'b0;
      BRITE_QTR:  nxt_scan_en = (phase_ff == 2'h0);
      BRITE_HALF: nxt_scan_en = !phase_ff[0];
      BRITE_FULL: nxt_scan_en = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      scan_cnt_ff <= '0;
      phase_ff    <= '0;
      scan_en_ff  <= 1'b0;
      bar_ff      <= NUM_MODES'(1);
      irq_ff      <= 1'b0;
    end
    else
    begin
      scan_cnt_ff <= nxt_scan_cnt;
      phase_ff    <= nxt_phase;
      scan_en_ff  <= nxt_scan_en;
      bar_ff      <= NUM_MODES'(1) << mode_ff;
      irq_ff      <= |(istat_ff & imask_ff);
    end
  end

  assign prdata_o   = prdata_ff;
  assign pready_o   = pready_ff;
  assign pslverr_o  = pslverr_ff;
  assign mode_bar_o = bar_ff;
  assign led_o      = led_ff;
  assign scan_en_o  = scan_en_ff;
  assign irq_o      = irq_ff;
  assign proc_irq_o = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_mode_onehot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $onehot(mode_bar_o)) else $error("mode lightbars not one-hot");
  chk_bright_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (brite_ff == BRITE_OFF) ##1 (brite_ff == BRITE_OFF) |-> !scan_en_o) else $error("scan on at zero brightness");
  chk_proc_irq_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !proc_irq_o) else $error("processor request driven");
  chk_key_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (&deb_lvl[NUM_KEYS-1:0]) |=> (key_code == KEY_NONE)) else $error("idle keypad code wrong");
  chk_key_clear_top: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !deb_lvl[NUM_KEYS-1] |=> (key_code == 4'h0)) else $error("clear key not top priority");
  chk_enc_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    trig_edge[0] |=> ev_ff[0] && (dir_ff[0] == $past(dir_s[0]))) else $error("encoder event not captured");
  chk_enc_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rd_done && (paddr_i == ADDR_ENC) && snap_ev_ff[1] ##1 !trig_edge[1] |=> !ev_ff[1])
    else $error("encoder flag not cleared after read");
  chk_enc_keep: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    enc_clr_ff && trig_edge[0] |=> ev_ff[0]) else $error("trigger lost to clear");
  chk_bus_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bus_clr |=> (mode_ff == MODE_RST) && (led_o == '0) ##1 mode_bar_o == NUM_MODES'(1))
    else $error("bus clear missed a latch");
  chk_read_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    psel_i && penable_i && !pwrite_i |-> $stable(snap_keys_ff) && $stable(snap_enc_ff))
    else $error("read word moved during strobe");
  chk_enc_idle_bus: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !psel_i ##1 !psel_i |-> prdata_o == 32'h0) else $error("read data driven outside read");
endmodule : front_panel_if

// [hw/key_encoder.sv]
// static priority encoder for the 15-key keypad
`timescale 1ns/1ps
module key_encoder
  import fp_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // pressed keys, active high, index 0 is digit zero
  input  wire logic [NUM_KEYS-1:0]   pressed_i,
  // complemented priority
  output logic [KEY_CODE_W-1:0]      code_o
);
  logic [KEY_CODE_W-1:0] code_ff;
  logic [KEY_CODE_W-1:0] nxt_code;

  // highest pressed index + 1; zero when nothing is pressed
  function automatic logic [KEY_CODE_W-1:0] top_prio(input logic [NUM_KEYS-1:0] p);
    logic [KEY_CODE_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_KEYS; i++)
    begin
      if (p[i])
      begin
        r = KEY_CODE_W'(i + 1);
      end
    end
    return r;
  endfunction : top_prio

  always_comb
  begin
    nxt_code = ~top_prio(pressed_i);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      code_ff <= KEY_NONE;
    end
    else
    begin
      code_ff <= nxt_code;
    end
  end

  assign code_o = code_ff;
endmodule : key_encoder

// [verif/proc_bus_model.sv]
// processor side bus master model speaking apb to the panel interface
`timescale 1ns/1ps
module proc_bus_model (
  // clock
  input  wire logic        clk_sys_i,
  // apb master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0;
  end

  // ----------------------------------------------------------------
  // one transfer; waits for pready with no assumed latency
  // ----------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    // read just after the edge, so these are the values the slave saw at that edge
    @(posedge clk_sys_i);
    while (pready_i !== 1'b1)
    begin
      @(posedge clk_sys_i);
    end
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : proc_bus_model

// [verif/tb_top.sv]
// self-checking bench for the front panel input interface
`timescale 1ns/1ps
module tb_top;
  import fp_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, scan, irq, pirq, e;
  logic [7:0]  paddr, led, b;
  logic [31:0] pwdata, prdata, q, v;
  logic [14:0] key_n = 15'h7FFF;
  logic [14:0] p;
  logic [7:0]  btn_n = 8'hFF;
  logic [1:0]  trig = 2'b00;
  logic [1:0]  dir = 2'b00;
  logic [9:0]  mbar;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;

  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  proc_bus_model proc_bus_model_i (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  front_panel_if #(.DEB_DIV(4), .SCAN_DIV(4)) front_panel_if_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .key_n_i(key_n), .btn_n_i(btn_n),
    .enc_trig_i(trig), .enc_dir_i(dir), .mode_bar_o(mbar), .led_o(led), .scan_en_o(scan),
    .irq_o(irq), .proc_irq_o(pirq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] kcode(input logic [14:0] k);
    kcode = 4'hF;
    for (int i = 0; i < 15; i++)
      if (k[i])
        kcode = ~(i[3:0] + 4'h1);
  endfunction : kcode

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    proc_bus_model_i.xfer(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a);
    proc_bus_model_i.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd

  task settle(input int c);
    repeat (c) @(negedge clk_sys_i);
  endtask : settle

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // a hang counts as a mismatch
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(87530));
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    settle(1);
    chk(mbar, 10'h001);
    rd(ADDR_KEYS);
    chk(q, 32'h0000FF0F);
    rd(ADDR_ENC);
    chk(q, 32'h0);
    $display("reset test done");
    for (int m = 0; m < 11; m++)
    begin
      wr(ADDR_MODE, m);
      settle(2);
      chk(mbar, 10'h001 << (m > 9 ? 9 : m));
    end
    $display("mode test done");
    for (int t = 0; t < 9; t++)
    begin
      n = $urandom_range(14, 0);
      p = (15'h1 << n) | (15'($urandom) & ((15'h1 << n) - 15'h1));
      p = t == 0 ? 15'h7FFF : t == 1 ? 15'h0001 : t == 2 ? 15'h0 : p;
      b = 8'($urandom);
      key_n <= ~p;
      btn_n <= b;
      repeat (40) @(posedge clk_sys_i);
      rd(ADDR_KEYS);
      chk(q[3:0], kcode(p));
      chk(q[15:8], b);
    end
    $display("keypad test done");
    for (int t = 0; t < 4; t++)
    begin
      v = $urandom;
      dir <= v[1:0];
      repeat (4) @(posedge clk_sys_i);
      trig <= 2'b11;
      repeat (6) @(posedge clk_sys_i);
      trig <= 2'b00;
      rd(ADDR_ENC);
      chk(q, {28'h0, v[1], 1'b1, v[0], 1'b1});
      rd(ADDR_ENC);
      chk(q, 32'h0);
    end
    trig <= 2'b01;
    repeat (4) @(posedge clk_sys_i);
    trig <= 2'b00;
    repeat (4) @(posedge clk_sys_i);
    // the second trigger lands in the clear cycle of this read and must survive it
    fork
      rd(ADDR_ENC);
      begin
        @(posedge clk_sys_i);
        trig <= 2'b01;
      end
    join
    chk(q, {30'h0, v[0], 1'b1});
    rd(ADDR_ENC);
    chk(q, {30'h0, v[0], 1'b1});
    rd(ADDR_ENC);
    chk(q, 32'h0);
    trig <= 2'b00;
    $display("encoder test done");
    wr(ADDR_ISTAT, 32'h7);
    wr(ADDR_IMASK, 32'h1);
    key_n <= ~15'h0010;
    repeat (40) @(posedge clk_sys_i);
    chk(irq, 1'b1);
    wr(ADDR_ISTAT, 32'h7);
    settle(2);
    chk(irq, 1'b0);
    wr(ADDR_IMASK, 32'h0);
    key_n <= 15'h7FFF;
    repeat (40) @(posedge clk_sys_i);
    chk(irq, 1'b0);
    $display("interrupt test done");
    for (int l = 0; l < 4; l++)
    begin
      wr(ADDR_BRITE, l);
      settle(20);
      n = 0;
      for (int c = 0; c < 64; c++)
      begin
        @(negedge clk_sys_i);
        n += int'(scan === 1'b1);
      end
      chk(n, l == 3 ? 64 : 16 * l);
    end
    $display("brightness test done");
    v = $urandom;
    wr(ADDR_LEDS, v[7:0]);
    rd(ADDR_LEDS);
    chk(q, v[7:0]);
    wr(ADDR_CTRL, 32'h1);
    settle(2);
    chk(led, 8'h00);
    chk(mbar, 10'h001);
    rd(ADDR_BRITE);
    chk(q, 32'h0);
    rd(8'h40);
    chk(q, 32'h0);
    chk(e, 1'b1);
    chk(pirq, 1'b0);
    $display("clear and bus test done");
    report_and_stop;
  end
endmodule : tb_top
